// File: common/eq_ctrl_pkg.sv
// Package: register map, field layout, reset values and codes for the
// equalizer state and detect control block.
// Assumes one clock domain and a simple parallel register port.
package eq_ctrl_pkg;
    // Register offsets
    localparam logic [3:0] boost_ch0_clk_off       = 4'h3;
    localparam logic [3:0] detect_assert_thr_off   = 4'h5;
    localparam logic [3:0] detect_deassert_thr_off = 4'h6;
    localparam logic [3:0] enable_source_off       = 4'h7;
    localparam logic [3:0] output_amplitude_off    = 4'h8;
    localparam logic [3:0] status_off              = 4'h0;
    // Field positions
    localparam int unsigned en_ctrl_bit   = 3;
    localparam int unsigned en_src_bit    = 0;
    localparam int unsigned amp_lsb       = 2;
    localparam int unsigned detect_status_bit = 0;
    // Reset values
    localparam logic [7:0] boost_ch0_clk_rst = 8'h77;
    localparam logic [7:0] thr_rst           = 8'h00;
    localparam logic [7:0] enable_source_rst = 8'h00;
    localparam logic [7:0] output_amp_rst    = 8'h78;
    // Output amplitude codes
    localparam logic [1:0] amp_540  = 2'h0;
    localparam logic [1:0] amp_770  = 2'h1;
    localparam logic [1:0] amp_1000 = 2'h2;
    localparam logic [1:0] amp_1200 = 2'h3;

    typedef enum logic {dev_standby, dev_active} dev_state_e;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Power enables to the analog channel blocks
    typedef struct packed {
        logic data_eq;
        logic data_amp;
        logic data_buf;
        logic clk_amp;
        logic clk_buf;
    } power_en_s;

    // Threshold decode: code to millivolts, assert and deassert tables
    function automatic logic [7:0] assert_mv(input logic [1:0] code);
        case (code)
            2'h0:    assert_mv = 8'h46; // 70
            2'h1:    assert_mv = 8'h37; // 55
            2'h2:    assert_mv = 8'h5A; // 90
            default: assert_mv = 8'h4B; // 75
        endcase
    endfunction : assert_mv

    function automatic logic [7:0] deassert_mv(input logic [1:0] code);
        case (code)
            2'h0:    deassert_mv = 8'h28; // 40
            2'h1:    deassert_mv = 8'h1E; // 30
            2'h2:    deassert_mv = 8'h37; // 55
            default: deassert_mv = 8'h2D; // 45
        endcase
    endfunction : deassert_mv
endpackage : eq_ctrl_pkg

// File: hdl/eq_state_detect_ctrl.sv
// Equalizer device-state, clock-channel detect and output-level control.
// Assumes a decoded serial-port register interface on clk_i and an
// analog comparator front end reporting the clock input amplitude in mV.
`timescale 1ns/1ns
`default_nettype none
module eq_state_detect_ctrl (
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   enable_pin_i,
    input  wire logic [7:0]             clk_amp_mv_i,
    input  wire eq_ctrl_pkg::reg_req_s  req_i,
    input  wire logic                   serial_clock_pin_i,
    input  wire logic                   serial_data_i,
    input  wire logic                   serial_sel_i,
    output var  logic [7:0]             rdata_o,
    output var  logic                   sig_present_flag_o,
    output var  logic [1:0]             amp_code_o,
    output var  eq_ctrl_pkg::dev_state_e dev_state_o,
    output var  eq_ctrl_pkg::power_en_s power_en_o,
    output var  logic                   serial_clock_pin_o,
    output var  logic                   serial_clock_pin_oe_b_o,
    output var  logic                   serial_data_pu_o,
    output var  logic                   serial_sel_pd_o
);
    // Pin synchronisers
    logic [1:0] en_sync_reg;
    logic [1:0] en_sync_next;
    logic [7:0] amp_s1_reg;
    logic [7:0] amp_s2_reg;

    // Configuration registers
    logic [7:0] boost_reg;
    logic [7:0] boost_next;
    logic [7:0] assert_thr_reg;
    logic [7:0] assert_thr_next;
    logic [7:0] deassert_thr_reg;
    logic [7:0] deassert_thr_next;
    logic [7:0] en_src_reg;
    logic [7:0] en_src_next;
    logic [7:0] out_amp_reg;
    logic [7:0] out_amp_next;

    // Detect and state outputs
    logic                   detect_reg;
    logic                   detect_next;
    logic [7:0]             rdata_next;
    eq_ctrl_pkg::dev_state_e state_next;
    eq_ctrl_pkg::power_en_s  pwr_next;

    // Enable pin sync, first stage read only by second
    always_comb begin
        en_sync_next = {en_sync_reg[0], enable_pin_i};
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_sync_reg <= 2'h0;
            amp_s1_reg  <= 8'h00;
            amp_s2_reg  <= 8'h00;
        end else begin
            en_sync_reg <= en_sync_next;
            amp_s1_reg  <= clk_amp_mv_i;
            amp_s2_reg  <= amp_s1_reg;
        end
    end

    // Register writes
    always_comb begin
        boost_next        = boost_reg;
        assert_thr_next   = assert_thr_reg;
        deassert_thr_next = deassert_thr_reg;
        en_src_next       = en_src_reg;
        out_amp_next      = out_amp_reg;
        if (req_i.wr) begin
            case (req_i.addr)
                eq_ctrl_pkg::boost_ch0_clk_off:       boost_next = req_i.wdata;
                eq_ctrl_pkg::detect_assert_thr_off:
                    assert_thr_next = {6'h00, req_i.wdata[1:0]};
                eq_ctrl_pkg::detect_deassert_thr_off:
                    deassert_thr_next = {6'h00, req_i.wdata[1:0]};
                eq_ctrl_pkg::enable_source_off:
                    en_src_next = {7'h00,
                                   req_i.wdata[eq_ctrl_pkg::en_src_bit]};
                eq_ctrl_pkg::output_amplitude_off:
                    // Only the level field changes, other bits keep reset
                    out_amp_next[eq_ctrl_pkg::amp_lsb +: 2] =
                        req_i.wdata[eq_ctrl_pkg::amp_lsb +: 2];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boost_reg        <= eq_ctrl_pkg::boost_ch0_clk_rst;
            assert_thr_reg   <= eq_ctrl_pkg::thr_rst;
            deassert_thr_reg <= eq_ctrl_pkg::thr_rst;
            en_src_reg       <= eq_ctrl_pkg::enable_source_rst;
            out_amp_reg      <= eq_ctrl_pkg::output_amp_rst;
        end else begin
            boost_reg        <= boost_next;
            assert_thr_reg   <= assert_thr_next;
            deassert_thr_reg <= deassert_thr_next;
            en_src_reg       <= en_src_next;
            out_amp_reg      <= out_amp_next;
        end
    end

    // Detect, state selection, power enables and read data
    always_comb begin
        detect_next = detect_reg;
        if (amp_s2_reg > eq_ctrl_pkg::assert_mv(assert_thr_reg[1:0])) begin
            detect_next = 1'b1;
        end else if (amp_s2_reg <
                     eq_ctrl_pkg::deassert_mv(deassert_thr_reg[1:0])) begin
            detect_next = 1'b0;
        end

        if (en_src_reg[eq_ctrl_pkg::en_src_bit]) begin
            state_next = boost_reg[eq_ctrl_pkg::en_ctrl_bit]
                       ? eq_ctrl_pkg::dev_standby : eq_ctrl_pkg::dev_active;
        end else begin
            state_next = en_sync_reg[1]
                       ? eq_ctrl_pkg::dev_active : eq_ctrl_pkg::dev_standby;
        end

        case (state_next)
            eq_ctrl_pkg::dev_active: pwr_next = '1;
            default:                 pwr_next = '0;
        endcase

        case (req_i.addr)
            eq_ctrl_pkg::status_off:
                rdata_next = {7'h00, detect_next};
            eq_ctrl_pkg::boost_ch0_clk_off:       rdata_next = boost_reg;
            eq_ctrl_pkg::detect_assert_thr_off:   rdata_next = assert_thr_reg;
            eq_ctrl_pkg::detect_deassert_thr_off:
                rdata_next = deassert_thr_reg;
            eq_ctrl_pkg::enable_source_off:       rdata_next = en_src_reg;
            eq_ctrl_pkg::output_amplitude_off:    rdata_next = out_amp_reg;
            default:                              rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            detect_reg         <= 1'b0;
            sig_present_flag_o <= 1'b0;
            dev_state_o        <= eq_ctrl_pkg::dev_standby;
            power_en_o         <= '0;
            rdata_o            <= 8'h00;
            amp_code_o         <= eq_ctrl_pkg::amp_1000;
        end else begin
            detect_reg         <= detect_next;
            sig_present_flag_o <= detect_next;
            dev_state_o        <= state_next;
            power_en_o         <= pwr_next;
            rdata_o            <= rdata_next;
            amp_code_o         <= out_amp_next[eq_ctrl_pkg::amp_lsb +: 2];
        end
    end

    // pull controls on open serial pins, clock pin never driven
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            serial_clock_pin_o      <= 1'b1;
            serial_clock_pin_oe_b_o <= 1'b1;
            serial_data_pu_o        <= 1'b1;
            serial_sel_pd_o         <= 1'b1;
        end else begin
            serial_clock_pin_o      <= 1'b1;
            serial_clock_pin_oe_b_o <= 1'b1;
            serial_data_pu_o        <= 1'b1;
            serial_sel_pd_o         <= 1'b1;
        end
    end
endmodule : eq_state_detect_ctrl
`default_nettype wire

// File: tb/eq_ctrl_sva.sv
// Checker: assertions on the state and detect control ports.
// Assumes a bind to the design top and one clock domain.
`timescale 1ns/1ns
`default_nettype none
module eq_ctrl_sva (
    input wire logic                    clk_i,
    input wire logic                    rst_b_i,
    input wire logic                    enable_pin_i,
    input wire logic [7:0]              clk_amp_mv_i,
    input wire eq_ctrl_pkg::reg_req_s   req_i,
    input wire logic [7:0]              rdata_o,
    input wire logic                    sig_present_flag_o,
    input wire logic [1:0]              amp_code_o,
    input wire eq_ctrl_pkg::dev_state_e dev_state_o,
    input wire eq_ctrl_pkg::power_en_s  power_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic src_reg;
    logic ctl_reg;
    // Shadow of the enable source and enable control bits
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            src_reg <= 1'b0;
            ctl_reg <= 1'b0;
        end else if (req_i.wr && req_i.addr == 4'h7) begin
            src_reg <= req_i.wdata[0];
        end else if (req_i.wr && req_i.addr == 4'h3) begin
            ctl_reg <= req_i.wdata[3];
        end
    end
    a_pin_active: assert property (
        (!src_reg && enable_pin_i) [*4] |-> dev_state_o == 1'b1)
        else $error("pin high but not active");
    a_pin_standby: assert property (
        (!src_reg && !enable_pin_i) [*4] |-> dev_state_o == 1'b0)
        else $error("pin low but not standby");
    a_bit_active: assert property (
        (src_reg && !ctl_reg) [*3] |-> dev_state_o == 1'b1)
        else $error("control bit clear but not active");
    a_power_state: assert property (
        power_en_o == {5{dev_state_o == eq_ctrl_pkg::dev_active}})
        else $error("block power does not follow state");
    a_detect_set: assert property (
        (clk_amp_mv_i > 8'h5A) [*4] |-> sig_present_flag_o)
        else $error("detect low above every assert level");
    a_detect_clear: assert property (
        (clk_amp_mv_i < 8'h1E) [*4] |-> !sig_present_flag_o)
        else $error("detect high below every deassert level");
    a_status_match: assert property (
        !req_i.wr && req_i.addr == 4'h0 |=> rdata_o[0] == sig_present_flag_o)
        else $error("status bit differs from detect pin");
    a_amp_write: assert property (
        req_i.wr && req_i.addr == 4'h8
        |=> amp_code_o == $past(req_i.wdata[3:2]))
        else $error("amplitude code not taken from write");
endmodule : eq_ctrl_sva
bind eq_state_detect_ctrl eq_ctrl_sva chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .enable_pin_i(enable_pin_i), .clk_amp_mv_i(clk_amp_mv_i), .req_i(req_i),
    .rdata_o(rdata_o), .sig_present_flag_o(sig_present_flag_o),
    .amp_code_o(amp_code_o), .dev_state_o(dev_state_o),
    .power_en_o(power_en_o));
`default_nettype wire

// File: tb/board_model.sv
// Board model: enable pin wiring, strap or detect loop-back.
// Assumes the bench picks the wiring and strap level.
`timescale 1ns/1ns
`default_nettype none
module board_model (
    input  wire logic tie_i,
    input  wire logic strap_i,
    input  wire logic detect_i,
    output var  logic enable_o
);
    assign enable_o = tie_i ? detect_i : strap_i;
endmodule : board_model
`default_nettype wire

// File: tb/tb_top.sv
// Testbench: register and pin tests of the state and detect control.
// Assumes the board model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic                    clk_i = 1'b0;
    logic                    rst_b_i = 1'b0;
    logic                    tie = 1'b0;
    logic                    strap = 1'b0;
    logic [7:0]              amp_mv = 8'h00;
    eq_ctrl_pkg::reg_req_s   req = '0;
    logic [7:0]              rdata;
    logic                    flag, en_pin, oe_b, pu, pd, sclk;
    logic [1:0]              amp_code;
    eq_ctrl_pkg::dev_state_e state;
    eq_ctrl_pkg::power_en_s  pwr;
    int                      n_mismatch = 0;
    int                      total_checks = 0;
    int                      cycles = 0;
    logic [7:0] on_t[4] = '{8'h46, 8'h37, 8'h5A, 8'h4B};
    logic [7:0] off_t[4] = '{8'h28, 8'h1E, 8'h37, 8'h2D};
    // Clock at 100 MHz
    always #5 clk_i = ~clk_i;
    board_model board_u (.tie_i(tie), .strap_i(strap), .detect_i(flag),
        .enable_o(en_pin));
    eq_state_detect_ctrl dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .enable_pin_i(en_pin), .clk_amp_mv_i(amp_mv), .req_i(req),
        .serial_clock_pin_i(1'b1), .serial_data_i(1'b1), .serial_sel_i(1'b0),
        .rdata_o(rdata), .sig_present_flag_o(flag), .amp_code_o(amp_code),
        .dev_state_o(state), .power_en_o(pwr), .serial_clock_pin_o(sclk),
        .serial_clock_pin_oe_b_o(oe_b), .serial_data_pu_o(pu),
        .serial_sel_pd_o(pd));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req = '{1'b1, a, d};
        @(negedge clk_i);
        req.wr = 1'b0;
        @(negedge clk_i);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        req.addr = a;
        @(negedge clk_i);
        chk(rdata, e);
    endtask : rd
    task automatic st(input logic act, input int n);
        repeat (n) @(negedge clk_i);
        chk({2'h0, pwr, state}, act ? 8'h3F : 8'h00);
    endtask : st
    task automatic detect_chk(input logic e);
        repeat (4) @(negedge clk_i);
        req.addr = 4'h0;
        @(negedge clk_i);
        chk({6'h0, rdata[0], flag}, e ? 8'h03 : 8'h00);
    endtask : detect_chk
    // Cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // Main sequence
    initial begin
        repeat (12) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        chk({4'h0, sclk, pu, pd, oe_b}, 8'h0F);
        chk({6'h0, amp_code}, 8'h02);
        rd(4'h5, 8'h00);
        rd(4'h6, 8'h00);
        rd(4'h8, 8'h78);
        rd(4'h9, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(4'h8, 8'(c << 2));
            chk({6'h0, amp_code}, 8'(c));
            rd(4'h8, 8'h70 | 8'(c << 2));
        end
        strap = 1'b1;
        st(1'b1, 4);
        strap = 1'b0;
        st(1'b0, 4);
        wr(4'h7, 8'h01);
        rd(4'h7, 8'h01);
        st(1'b1, 2);
        strap = 1'b1;
        wr(4'h3, 8'h7F);
        st(1'b0, 2);
        wr(4'h3, 8'h77);
        wr(4'h7, 8'h00);
        // Boost field 0x40 is stored and read back unchanged
        wr(4'h3, 8'h40);
        rd(4'h3, 8'h40);
        for (int c = 0; c < 4; c++) begin
            wr(4'h5, 8'hFC | 8'(c));
            wr(4'h6, 8'(c));
            rd(4'h5, 8'(c));
            amp_mv = on_t[c] + 8'h01;
            detect_chk(1'b1);
            amp_mv = off_t[c];
            detect_chk(1'b1);
            amp_mv = off_t[c] - 8'h01;
            detect_chk(1'b0);
            amp_mv = on_t[c];
            detect_chk(1'b0);
        end
        tie = 1'b1;
        amp_mv = 8'h80;
        st(1'b1, 8);
        amp_mv = 8'h10;
        st(1'b0, 8);
        // Reset again mid-run: configuration returns to its defaults
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        chk({6'h0, amp_code}, 8'h02);
        rd(4'h5, 8'h00);
        rd(4'h6, 8'h00);
        rd(4'h8, 8'h78);
        st(1'b0, 4);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
